/* File: design/crs_regs.sv */
// Programmer-visible CPU register set with reset vector and stack pusher
`timescale 1ns/10ps
module crs_regs
    import crs_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Command port
    input  wire logic        cmd_valid,
    input  crs_cmd_s         cmd,
    output logic             cmd_ready,
    // ALU result path
    input  crs_alu_s         alu_in,
    output logic [7:0]       alu_operand,
    // Memory bus
    output crs_bus_s         bus,
    input  wire logic [7:0]  bus_rdata,
    // Register views and address helpers
    output logic [7:0]       result_holder,
    output logic [15:0]      pointer_pair,
    output logic [15:0]      stack_ptr,
    output logic [15:0]      fetch_pointer,
    output logic [7:0]       flags_byte,
    output logic [15:0]      direct_addr
);
    typedef enum logic [1:0] {S_VEC_HI, S_VEC_LO, S_RUN, S_PUSH} crs_state_e;
    crs_state_e  state_reg;
    logic [7:0]  acc_reg, x_reg, h_reg, flags_reg, rem;
    logic [15:0] sp_reg, pc_reg, tgt_reg, prod, quot;
    logic [2:0]  step_reg, len_reg;
    logic        intr_reg, run, push_last, push_cmd;
    crs_alu_s    xu;

    // Short address form always lands in the first page
    function automatic logic [15:0] dir_addr(input logic [7:0] a);
        return {CRS_DIRECT_PAGE, a};
    endfunction
    function automatic logic x_only(input crs_op_e op);
        return op inside {OP_LDX, OP_TAX, OP_X_CLR, OP_X_INC, OP_X_DEC,
                          OP_X_COM, OP_X_NEG, OP_X_LSL, OP_X_LSR,
                          OP_X_ROL, OP_X_ROR};
    endfunction
    // Second data register operations on the index low byte
    function automatic crs_alu_s x_unary(input crs_op_e op,
                                         input logic [7:0] x,
                                         input logic cin);
        crs_alu_s r;
        r = '0;
        r.c = cin;
        case (op)
            OP_X_CLR: r.res = 8'h00;
            OP_X_INC: {r.v, r.res} = {x == 8'h7f, x + 8'h01};
            OP_X_DEC: {r.v, r.res} = {x == 8'h80, x - 8'h01};
            OP_X_COM: {r.c, r.res} = {1'b1, ~x};
            OP_X_NEG: {r.v, r.c, r.res} = {x == 8'h80, x != 8'h00, 8'h00 - x};
            OP_X_LSL: {r.c, r.res} = {x, 1'b0};
            OP_X_LSR: {r.res, r.c} = {1'b0, x};
            OP_X_ROL: {r.c, r.res} = {x, cin};
            OP_X_ROR: {r.res, r.c} = {cin, x};
            default:  r.res = x;
        endcase
        r.n = r.res[7];
        r.z = (r.res == 8'h00);
        if (op inside {OP_X_LSL, OP_X_LSR, OP_X_ROL, OP_X_ROR}) begin
            r.v = r.n ^ r.c;
        end
        return r;
    endfunction
    // Byte pushed at each step: return address low first, then registers
    function automatic logic [7:0] push_byte(input logic [2:0] s,
                                             input logic [15:0] pc,
                                             input logic [7:0] x, a, f);
        case (s)
            3'h0:    return pc[7:0];
            3'h1:    return pc[15:8];
            3'h2:    return x;
            3'h3:    return a;
            default: return f;
        endcase
    endfunction
    assign cmd_ready = (state_reg == S_RUN);
    assign run = ce && cmd_valid && cmd_ready;
    assign push_cmd = run && cmd.op inside {OP_CALL, OP_INTR};
    assign push_last = (state_reg == S_PUSH) && (step_reg == len_reg - 3'h1);
    assign xu = x_unary(cmd.op, x_reg, flags_reg[CRS_FC]);
    assign prod = 16'(x_reg) * 16'(acc_reg);
    assign quot = (x_reg == 8'h00) ? 16'hffff : {h_reg, acc_reg} / x_reg;
    assign rem = (x_reg == 8'h00) ? h_reg : 8'({h_reg, acc_reg} % x_reg);

    // Bus carries only vector reads and stack pushes; registers stay unmapped
    always_comb begin
        bus = '0;
        case (state_reg)
            S_VEC_HI, S_VEC_LO: begin
                bus.addr = (state_reg == S_VEC_HI) ? CRS_VEC_HI_ADDR
                                                   : CRS_VEC_LO_ADDR;
                bus.rd = 1'b1;
            end
            S_PUSH: begin
                bus.addr = sp_reg;
                bus.wr = 1'b1;
                bus.wdata = push_byte(step_reg, pc_reg, x_reg, acc_reg,
                                      flags_byte);
            end
            default: bus = '0;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= S_VEC_HI;
        end else if (ce) begin
            case (state_reg)
                S_VEC_HI: state_reg <= S_VEC_LO;
                S_VEC_LO: state_reg <= S_RUN;
                S_RUN:    state_reg <= push_cmd ? S_PUSH : S_RUN;
                S_PUSH:   state_reg <= push_last ? S_RUN : S_PUSH;
                default: state_reg <= S_RUN;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            step_reg <= '0;
            len_reg <= CRS_CALL_BYTES;
            intr_reg <= 1'b0;
            tgt_reg <= CRS_PC_RST;
        end else if (ce) begin
            if (run) begin
                step_reg <= '0;
                intr_reg <= (cmd.op == OP_INTR);
                len_reg <= (cmd.op == OP_INTR) ? CRS_INTR_BYTES
                                               : CRS_CALL_BYTES;
                tgt_reg <= cmd.target;
            end else if (state_reg == S_PUSH) begin
                step_reg <= step_reg + 3'h1;
            end
        end
    end

    // Vector high byte comes from the lower address
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pc_reg <= CRS_PC_RST;
        end else if (ce) begin
            if (state_reg == S_VEC_HI) begin
                pc_reg[15:8] <= bus_rdata;
            end else if (state_reg == S_VEC_LO) begin
                pc_reg[7:0] <= bus_rdata;
            end else if (push_last) begin
                pc_reg <= tgt_reg;
            end else if (run && cmd.op == OP_FETCH) begin
                pc_reg <= pc_reg + 16'h0001;
            end else if (run && cmd.op == OP_JUMP) begin
                pc_reg <= cmd.target;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sp_reg <= CRS_SP_RST;
        end else if (ce) begin
            if (state_reg == S_PUSH) begin
                sp_reg <= sp_reg - 16'h0001;
            end else if (run && cmd.op == OP_AIS) begin
                sp_reg <= sp_reg + {{8{cmd.imm[7]}}, cmd.imm};
            end else if (run && cmd.op == OP_RSP) begin
                sp_reg[7:0] <= CRS_SP_REINIT;
            end else if (run && cmd.op == OP_LDSP) begin
                sp_reg <= cmd.target;
            end
        end
    end

    // No reset: accumulator content survives reset by design
    always_ff @(posedge clock) begin
        if (ce && run) begin
            case (cmd.op)
                OP_LDA:  acc_reg <= cmd.imm;
                OP_ALU:  acc_reg <= alu_in.res;
                OP_TXA:  acc_reg <= x_reg;
                OP_MUL:  acc_reg <= prod[7:0];
                OP_DIV:  acc_reg <= (quot[15:8] == 8'h00) ? quot[7:0]
                                                          : acc_reg;
                default: acc_reg <= acc_reg;
            endcase
        end
    end

    // Index low byte also keeps its value across reset
    always_ff @(posedge clock) begin
        if (ce && run) begin
            case (cmd.op)
                OP_LDX:  x_reg <= cmd.imm;
                OP_LDHX: x_reg <= cmd.target[7:0];
                OP_TAX:  x_reg <= acc_reg;
                OP_MUL:  x_reg <= prod[15:8];
                default: begin
                    if (x_only(cmd.op)) begin
                        x_reg <= xu.res;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            h_reg <= CRS_H_RST;
        end else if (ce && run) begin
            if (cmd.op == OP_LDH) begin
                h_reg <= cmd.imm;
            end else if (cmd.op == OP_LDHX) begin
                h_reg <= cmd.target[15:8];
            end else if (cmd.op == OP_DIV && quot[15:8] == 8'h00) begin
                h_reg <= rem;
            end
        end
    end

    // Interrupt mask set on entry after registers are stacked
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= CRS_FLAGS_RST;
        end else if (ce) begin
            if (push_last && intr_reg) begin
                flags_reg[CRS_FI] <= 1'b1;
            end else if (run && cmd.op == OP_ALU) begin
                flags_reg[CRS_FV] <= alu_in.v;
                flags_reg[CRS_FH] <= alu_in.h;
                flags_reg[CRS_FN] <= alu_in.n;
                flags_reg[CRS_FZ] <= alu_in.z;
                flags_reg[CRS_FC] <= alu_in.c;
            end else if (run && x_only(cmd.op)) begin
                flags_reg[CRS_FV] <= xu.v;
                flags_reg[CRS_FN] <= xu.n;
                flags_reg[CRS_FZ] <= xu.z;
                flags_reg[CRS_FC] <= xu.c;
            end else if (run && cmd.op == OP_MUL) begin
                flags_reg[CRS_FH] <= 1'b0;
                flags_reg[CRS_FC] <= 1'b0;
            end else if (run && cmd.op == OP_DIV) begin
                flags_reg[CRS_FC] <= (quot[15:8] != 8'h00);
                flags_reg[CRS_FZ] <= (quot[7:0] == 8'h00);
            end else if (run && cmd.op == OP_SETF) begin
                flags_reg <= cmd.imm;
            end
        end
    end

    assign result_holder = acc_reg;
    assign alu_operand = acc_reg;
    assign pointer_pair = {h_reg, x_reg};
    assign stack_ptr = sp_reg;
    assign fetch_pointer = pc_reg;
    assign flags_byte = flags_reg | CRS_FLAGS_ONES;
    assign direct_addr = dir_addr(cmd.imm);

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_sp_rst;
        state_reg == S_VEC_HI |-> stack_ptr == CRS_SP_RST;
    endproperty
    a_sp_rst: assert property (p_sp_rst) else $error("sp reset");
    property p_h_rst;
        state_reg == S_VEC_HI |-> pointer_pair[15:8] == CRS_H_RST;
    endproperty
    a_h_rst: assert property (p_h_rst) else $error("h reset");
    property p_vec;
        state_reg == S_VEC_HI && ce ##1 ce |=>
            fetch_pointer == {$past(bus_rdata, 2), $past(bus_rdata)};
    endproperty
    a_vec: assert property (p_vec) else $error("vector order");
    property p_vec_addr;
        state_reg == S_VEC_HI && ce |-> bus.addr == CRS_VEC_HI_ADDR
            ##1 bus.addr == CRS_VEC_LO_ADDR && bus.rd;
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vec addr");
    property p_fetch;
        run && cmd.op == OP_FETCH |=> fetch_pointer == $past(pc_reg) + 16'h1;
    endproperty
    a_fetch: assert property (p_fetch) else $error("pc step");
    property p_ais;
        run && cmd.op == OP_AIS |=>
            stack_ptr == $past(sp_reg) + {{8{$past(cmd.imm[7])}},
                                           $past(cmd.imm)};
    endproperty
    a_ais: assert property (p_ais) else $error("stack adjust");
    property p_rsp;
        run && cmd.op == OP_RSP |=>
            stack_ptr == {$past(sp_reg[15:8]), CRS_SP_REINIT};
    endproperty
    a_rsp: assert property (p_rsp) else $error("stack reinit");
    property p_xonly;
        run && x_only(cmd.op) |=> pointer_pair[15:8] == $past(h_reg);
    endproperty
    a_xonly: assert property (p_xonly) else $error("h touched");
    property p_call;
        run && cmd.op == OP_CALL |=> bus.wr && bus.addr == $past(sp_reg)
            && bus.wdata == $past(pc_reg[7:0]);
    endproperty
    a_call: assert property (p_call) else $error("call push");
    property p_ones;
        flags_byte[6:5] == 2'b11
            && (!(push_last && intr_reg) || bus.wdata[6:5] == 2'b11);
    endproperty
    a_ones: assert property (p_ones) else $error("flag ones");
    c_boot: cover property (state_reg == S_VEC_LO ##1 state_reg == S_RUN);
    c_intr: cover property (run && cmd.op == OP_INTR);
    c_div: cover property (run && cmd.op == OP_DIV);
endmodule

/* File: design/crs_pkg.sv */
// Constants, commands and carriers for the CPU register set
package crs_pkg;
    localparam logic [15:0] CRS_SP_RST      = 16'h00ff;
    localparam logic [15:0] CRS_VEC_HI_ADDR = 16'hfffe;
    localparam logic [15:0] CRS_VEC_LO_ADDR = 16'hffff;
    localparam logic [15:0] CRS_PC_RST      = 16'h0000;
    localparam logic [7:0]  CRS_H_RST       = 8'h00;
    localparam logic [7:0]  CRS_DIRECT_PAGE = 8'h00;
    localparam logic [7:0]  CRS_SP_REINIT   = 8'hff;
    localparam logic [7:0]  CRS_FLAGS_ONES  = 8'h60;
    localparam logic [7:0]  CRS_FLAGS_RST   = 8'h68;
    localparam int          CRS_FV          = 7;
    localparam int          CRS_FH          = 4;
    localparam int          CRS_FI          = 3;
    localparam int          CRS_FN          = 2;
    localparam int          CRS_FZ          = 1;
    localparam int          CRS_FC          = 0;
    localparam logic [2:0]  CRS_CALL_BYTES  = 3'h2;
    localparam logic [2:0]  CRS_INTR_BYTES  = 3'h5;

    typedef enum logic [4:0] {
        OP_NOP, OP_FETCH, OP_JUMP, OP_CALL, OP_INTR, OP_LDA, OP_ALU,
        OP_LDX, OP_LDH, OP_LDHX, OP_TAX, OP_TXA, OP_X_CLR, OP_X_INC,
        OP_X_DEC, OP_X_COM, OP_X_NEG, OP_X_LSL, OP_X_LSR, OP_X_ROL,
        OP_X_ROR, OP_AIS, OP_RSP, OP_LDSP, OP_MUL, OP_DIV, OP_SETF
    } crs_op_e;

    typedef struct packed {
        crs_op_e     op;
        logic [7:0]  imm;
        logic [15:0] target;
    } crs_cmd_s;

    typedef struct packed {
        logic [7:0] res;
        logic       v;
        logic       h;
        logic       n;
        logic       z;
        logic       c;
    } crs_alu_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } crs_bus_s;
endpackage

/* File: tb/crs_mem_model.sv */
// Behavioural memory on the far side of the register set's bus
`timescale 1ns/10ps
module crs_mem_model
    import crs_pkg::*;
#(
    parameter logic [15:0] VECTOR = 16'hc35a
)(
    // Clock and enable
    input  wire logic       clock,
    input  wire logic       ce,
    // Bus
    input  crs_bus_s        bus,
    output logic [7:0]      bus_rdata
);
    logic [7:0] mem [int];
    logic [7:0] last;
    int         nwr;

    function automatic logic [7:0] rd_byte(input logic [15:0] a,
                                           input logic [7:0] l);
        if (mem.exists(a)) begin
            return mem[a];
        end
        return ~l;
    endfunction

    initial begin
        mem[CRS_VEC_HI_ADDR] = VECTOR[15:8];
        mem[CRS_VEC_LO_ADDR] = VECTOR[7:0];
        last = 8'h00;
        nwr = 0;
    end

    // Idle bus shows the inverse of the last byte, never a stale copy
    assign bus_rdata = bus.rd ? rd_byte(bus.addr, last) : ~last;

    always @(posedge clock) begin
        if (ce && bus.wr) begin
            mem[bus.addr] = bus.wdata;
            nwr++;
        end
        if (ce && bus.rd) begin
            last <= bus_rdata;
        end
    end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the CPU register set
`timescale 1ns/10ps
module tb;
    import crs_pkg::*;
    localparam logic [15:0] VEC = 16'hc35a;
    logic        clock, rstn, ce, cmd_valid, cmd_ready;
    crs_cmd_s    cmd;
    crs_alu_s    alu_in;
    crs_bus_s    bus;
    logic [7:0]  bus_rdata, result_holder, alu_operand, flags_byte;
    logic [15:0] pointer_pair, stack_ptr, fetch_pointer, direct_addr;
    int          miscompares, comparisons, seed, nwr_exp, i;
    logic [7:0]  m_a, m_x, m_h, m_f, f0;
    logic [15:0] m_sp, m_pc, sp0, pc0, r;
    logic        m_i, f_ok, c, do_c;
    crs_op_e     xop [11] = '{OP_X_CLR, OP_X_INC, OP_X_DEC, OP_X_COM,
        OP_X_NEG, OP_X_LSL, OP_X_LSR, OP_X_ROL, OP_X_ROR, OP_TAX, OP_TXA};
    logic [23:0] dv [3] = '{24'h010010, 24'h200010, 24'h050000};

    crs_regs uut (.clock(clock), .rstn(rstn), .ce(ce),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .alu_in(alu_in), .alu_operand(alu_operand), .bus(bus),
        .bus_rdata(bus_rdata), .result_holder(result_holder),
        .pointer_pair(pointer_pair), .stack_ptr(stack_ptr),
        .fetch_pointer(fetch_pointer), .flags_byte(flags_byte),
        .direct_addr(direct_addr));
    crs_mem_model #(.VECTOR(VEC)) mem (.clock(clock), .ce(ce), .bus(bus),
        .bus_rdata(bus_rdata));

    initial clock = 1'b0;
    always #5 clock = ~clock;

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task wait_ready;
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        chk(16'(cmd_ready), 16'h1);
    endtask

    task check_all;
        chk(16'(result_holder), 16'(m_a));
        chk(16'(alu_operand), 16'(m_a));
        chk(pointer_pair, {m_h, m_x});
        chk(stack_ptr, m_sp);
        chk(fetch_pointer, m_pc);
        chk(16'(flags_byte[6:5]), 16'h3);
        if (f_ok) chk(16'(flags_byte), 16'(m_f));
    endtask

    task model(input crs_op_e op, input logic [7:0] imm,
               input logic [15:0] t);
        logic [15:0] hx;
        hx = {m_h, m_a};
        f_ok &= op inside {OP_FETCH, OP_JUMP, OP_CALL, OP_INTR, OP_AIS,
                           OP_RSP};
        case (op)
            OP_FETCH: m_pc = m_pc + 16'h1;
            OP_JUMP:  m_pc = t;
            OP_CALL: begin
                m_sp = m_sp - 16'h2;
                m_pc = t;
                nwr_exp += 2;
            end
            OP_INTR: begin
                m_sp = m_sp - 16'h5;
                m_pc = t;
                m_i = 1'b1;
                m_f[CRS_FI] = 1'b1;
                nwr_exp += 5;
            end
            OP_LDA:   m_a = imm;
            OP_ALU: begin
                m_a = alu_in.res;
                m_f = {alu_in.v, 2'h3, alu_in.h, m_i, alu_in.n, alu_in.z,
                       alu_in.c};
                f_ok = 1'b1;
            end
            OP_LDX:   m_x = imm;
            OP_LDHX:  {m_h, m_x} = t;
            OP_TAX:   m_x = m_a;
            OP_TXA:   m_a = m_x;
            OP_X_CLR: m_x = 8'h00;
            OP_X_INC: m_x = m_x + 8'h1;
            OP_X_DEC: m_x = m_x - 8'h1;
            OP_X_COM: m_x = ~m_x;
            OP_X_NEG: m_x = 8'h00 - m_x;
            OP_X_LSL: m_x = {m_x[6:0], 1'b0};
            OP_X_LSR: m_x = {1'b0, m_x[7:1]};
            OP_X_ROL: m_x = {m_x[6:0], m_f[0]};
            OP_X_ROR: m_x = {m_f[0], m_x[7:1]};
            OP_AIS:   m_sp = m_sp + {{8{imm[7]}}, imm};
            OP_RSP:   m_sp[7:0] = CRS_SP_REINIT;
            OP_LDSP:  m_sp = t;
            OP_MUL:   {m_x, m_a} = 16'(m_x) * 16'(m_a);
            OP_DIV: begin
                if (m_x != 8'h00 && hx / m_x < 16'h100) begin
                    m_a = 8'(hx / m_x);
                    m_h = 8'(hx % m_x);
                end
            end
            OP_SETF: begin
                m_f = imm | CRS_FLAGS_ONES;
                m_i = imm[CRS_FI];
                f_ok = 1'b1;
            end
            default: ;
        endcase
    endtask

    task do_cmd(input crs_op_e op, input logic [7:0] imm,
                input logic [15:0] t);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd = '{op: op, imm: imm, target: t};
        #1;
        chk(direct_addr, {CRS_DIRECT_PAGE, imm});
        wait_ready;
        @(negedge clock);
        cmd_valid = 1'b0;
        wait_ready;
        model(op, imm, t);
        check_all;
    endtask

    task do_reset;
        @(negedge clock);
        rstn = 1'b0;
        repeat (3) @(negedge clock);
        rstn = 1'b1;
        {m_sp, m_h, m_pc, m_f} = {CRS_SP_RST, CRS_H_RST, VEC, CRS_FLAGS_RST};
        m_i = 1'b1;
        f_ok = 1'b1;
        wait_ready;
        chk(16'(pointer_pair[15:8]), 16'h0);
        chk(stack_ptr, CRS_SP_RST);
        chk(fetch_pointer, VEC);
    endtask

    initial begin
        {miscompares, comparisons, nwr_exp} = '0;
        seed = 10;
        {rstn, ce, cmd_valid} = 3'b010;
        cmd = '0;
        alu_in = '0;
        do_reset;
        r = 16'($random(seed));
        do_cmd(OP_LDA, r[7:0], 16'h0);
        do_cmd(OP_LDHX, 8'h00, 16'($random(seed)));
        do_cmd(OP_LDX, 8'ha5, 16'h0);
        for (i = 0; i < 11; i++) begin
            r = 16'($random(seed));
            do_cmd(OP_LDX, r[15:8], 16'h0);
            do_cmd(OP_SETF, r[7:0], 16'h0);
            do_c = 1'b1;
            case (xop[i])
                OP_X_LSL, OP_X_ROL: c = m_x[7];
                OP_X_LSR, OP_X_ROR: c = m_x[0];
                OP_X_COM:           c = 1'b1;
                OP_X_NEG:           c = (m_x != 8'h00);
                default:            do_c = 1'b0;
            endcase
            do_cmd(xop[i], 8'h00, 16'h0);
            if (do_c) chk(16'(flags_byte[CRS_FC]), 16'(c));
        end
        for (i = 0; i < 8; i++) begin
            alu_in = crs_alu_s'($random(seed));
            do_cmd(OP_ALU, 8'h00, 16'h0);
        end
        do_cmd(OP_LDSP, 8'h00, 16'h1234);
        do_cmd(OP_AIS, 8'h80, 16'h0);
        do_cmd(OP_AIS, 8'h7f, 16'h0);
        do_cmd(OP_AIS, 8'h01, 16'h0);
        do_cmd(OP_RSP, 8'h00, 16'h0);
        do_cmd(OP_JUMP, 8'h00, 16'hffff);
        do_cmd(OP_FETCH, 8'h00, 16'h0);
        do_cmd(OP_FETCH, 8'h00, 16'h0);
        {sp0, pc0} = {m_sp, m_pc};
        do_cmd(OP_CALL, 8'h00, 16'h4000);
        chk(16'(mem.mem[sp0]), 16'(pc0[7:0]));
        chk(16'(mem.mem[sp0 - 16'h1]), 16'(pc0[15:8]));
        do_cmd(OP_SETF, 8'h00, 16'h0);
        {sp0, pc0, f0} = {m_sp, m_pc, m_f};
        do_cmd(OP_INTR, 8'h00, 16'h8000);
        chk({mem.mem[sp0 - 16'h1], mem.mem[sp0]}, pc0);
        chk({mem.mem[sp0 - 16'h2], mem.mem[sp0 - 16'h3]},
            {m_x, m_a});
        chk(16'(mem.mem[sp0 - 16'h4]), 16'(f0));
        chk(16'(mem.nwr), 16'(nwr_exp));
        do_cmd(OP_LDA, 8'hff, 16'h0);
        do_cmd(OP_LDX, 8'hff, 16'h0);
        do_cmd(OP_MUL, 8'h00, 16'h0);
        for (i = 0; i < 3; i++) begin
            // Entries are dividend high, dividend low, divisor
            do_cmd(OP_LDHX, 8'h00, {dv[i][23:16], dv[i][7:0]});
            do_cmd(OP_LDA, dv[i][15:8], 16'h0);
            do_cmd(OP_DIV, 8'h00, 16'h0);
            chk(16'(flags_byte[CRS_FC]), 16'(i > 0));
        end
        do_reset;
        check_all;
        // Clock enable low must freeze a pending fetch
        @(negedge clock);
        ce = 1'b0;
        cmd_valid = 1'b1;
        cmd = '{op: OP_FETCH, imm: 8'h00, target: 16'h0};
        repeat (3) @(negedge clock);
        chk(fetch_pointer, m_pc);
        {ce, cmd_valid} = 2'b10;
        final_report;
    end

    initial begin
        #200000;
        miscompares++;
        final_report;
    end
endmodule
